/* File: shared/pt_pkg.sv */
// Package of register map, field layout and mode codes for the pulse timer unit
// Function
// - Compare match A reloads A from buffer C
// - Capture stores counter, old A moves to C
// - Per-register match action: low, high, toggle
// - Clear-on-match register sets period; per-channel, syncable
// - Mode 1 pairs A/B on pin A, C/D on pin C
// - Mode 1: A/C and B/D select fields apply
// - Mode 1 pins start at A/C initial level
// - Mode 1 equal pair values leave pin unchanged
// - Mode 1 gives at most four phases
// - Mode 2: one cycle register, rest duty registers
// - Mode 2 cycle clear restores initial levels
// - Mode 2 duty equal to cycle: no change
// - Mode 2 with sync gives up to seven phases
// - Fixed register to pin map per channel and mode
// - Mode 2 cycle register pin stays undriven
// - Quadrature counting only on channels 1 and 2
// - Quadrature ignores prescale/edge; clear, compare, capture work
// - Overflow up sets overflow; underflow down sets underflow
// - Readable count direction status bit
// - Channel 1 uses pins A/B, channel 2 C/D
// - Four selectable phase counting variants
// - Variant 1 up/down edge-level combinations
// - Counter wraps all ones to zero
// - Match clear zeroes counter and sets flag
package pt_pkg;

  // Register index inside a channel (address bits [3:0])
  localparam logic [3:0] PT_REG_CTRL   = 4'h0;
  localparam logic [3:0] PT_REG_IOCTL  = 4'h1;
  localparam logic [3:0] PT_REG_STATUS = 4'h2;
  localparam logic [3:0] PT_REG_COUNT  = 4'h3;
  localparam logic [3:0] PT_REG_CC_A   = 4'h4;
  localparam logic [3:0] PT_REG_CC_B   = 4'h5;
  localparam logic [3:0] PT_REG_CC_C   = 4'h6;
  localparam logic [3:0] PT_REG_CC_D   = 4'h7;
  // Channel slot 3 holds the sync enable register
  localparam logic [1:0] PT_SYNC_SLOT  = 2'h3;
  localparam logic [3:0] PT_REG_SYNC   = 4'h0;

  // Status bit positions
  localparam int PT_ST_OVF = 4;
  localparam int PT_ST_UNF = 5;
  localparam int PT_ST_DIR = 6;

  // Output select nibble bit positions
  localparam int PT_IO_CAPTURE = 3;
  localparam int PT_IO_INIT    = 2;

  // Match actions and capture edges (nibble bits [1:0])
  localparam logic [1:0] PT_ACT_NONE   = 2'h0;
  localparam logic [1:0] PT_ACT_LOW    = 2'h1;
  localparam logic [1:0] PT_ACT_HIGH   = 2'h2;
  localparam logic [1:0] PT_ACT_TOGGLE = 2'h3;
  localparam logic [1:0] PT_EDGE_RISE  = 2'h0;
  localparam logic [1:0] PT_EDGE_FALL  = 2'h1;

  // Counter clear sources
  localparam logic [2:0] PT_CLR_NONE = 3'h0;
  localparam logic [2:0] PT_CLR_SYNC = 3'h5;

  // Prescaler tap masks for divide by 4, 16, 64
  localparam logic [5:0] PT_DIV4_MASK  = 6'h03;
  localparam logic [5:0] PT_DIV16_MASK = 6'h0f;
  localparam logic [5:0] PT_DIV64_MASK = 6'h3f;

  // Reset values
  localparam logic [15:0] PT_CTRL_RST   = 16'h0000;
  localparam logic [15:0] PT_IOCTL_RST  = 16'h0000;
  localparam logic [6:0]  PT_STATUS_RST = 7'h40;
  localparam logic [2:0]  PT_SYNC_RST   = 3'h0;

  typedef enum logic [1:0] {
    PT_MODE_NORMAL = 2'b00,
    PT_MODE_PWM1   = 2'b01,
    PT_MODE_PWM2   = 2'b10,
    PT_MODE_PHASE  = 2'b11
  } pt_mode_e;

  typedef struct packed {
    logic       spare;
    logic       start;
    logic       buffer_b;
    logic       buffer_a;
    logic [1:0] phase_variant;
    pt_mode_e   mode;
    logic [2:0] clear_source;
    logic [1:0] clock_edge_select;
    logic [2:0] prescale_select;
  } pt_ctrl_s;

endpackage

/* File: logic/pt_pulse_timer_unit.sv */
// Three-channel pulse timer: buffering, PWM modes 1/2 and quadrature counting
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module pt_pulse_timer_unit
  import pt_pkg::*;
#(
  parameter int NUM_CH = 3
) (
  input  wire logic        CLOCK_IN,
  input  wire logic        RESET_N_IN,
  input  wire logic [5:0]  ADDR_IN,
  input  wire logic [15:0] WDATA_IN,
  input  wire logic        WR_IN,
  input  wire logic        RD_IN,
  output logic      [15:0] RDATA_OUT,
  input  wire logic [11:0] WAVE_PIN_IN,
  output logic      [11:0] WAVE_PIN_OUT,
  output logic      [11:0] WAVE_PIN_OE_N_OUT,
  input  wire logic [3:0]  EXT_CLOCK_PIN_IN
);

  if (NUM_CH != 3) begin : g_bad_param
    $error("NUM_CH must be 3: pins and sync slot are laid out for three channels");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared state

  pt_ctrl_s    ctrl_reg  [NUM_CH];
  logic [15:0] io_reg    [NUM_CH];
  logic [6:0]  stat_reg  [NUM_CH];
  logic [15:0] cnt       [NUM_CH];
  logic [15:0] cc_reg    [NUM_CH][4];
  logic [2:0]  sync_en;
  logic [5:0]  div_cnt;
  logic [3:0]  ext_s1;
  logic [3:0]  ext_s2;
  logic [3:0]  ext_d;
  logic [11:0] pin_prev;
  logic [NUM_CH-1:0] self_clr_v;
  logic [1:0]  addr_ch;
  logic [3:0]  addr_reg;
  logic        sync_cnt_wr;

  assign addr_ch     = ADDR_IN[5:4];
  assign addr_reg    = ADDR_IN[3:0];
  assign sync_cnt_wr = WR_IN && addr_reg == PT_REG_COUNT && addr_ch != PT_SYNC_SLOT
                       && sync_en[addr_ch];

  // Apply a match action to the current pin level
  function automatic logic pt_apply(input logic cur, input logic [1:0] act);
    logic r;
    r = cur;
    unique case (act)
      PT_ACT_NONE:   r = cur;
      PT_ACT_LOW:    r = 1'b0;
      PT_ACT_HIGH:   r = 1'b1;
      PT_ACT_TOGGLE: r = ~cur;
    endcase
    return r;
  endfunction

  // Quadrature decode: returns {up, down} for the selected variant
  function automatic logic [1:0] pt_quad(input logic [1:0] v, input logic a,
                                         input logic b, input logic pa, input logic pb);
    logic ar, af, br, bf, up, dn;
    ar = a & ~pa;
    af = ~a & pa;
    br = b & ~pb;
    bf = ~b & pb;
    up = 1'b0;
    dn = 1'b0;
    unique case (v)
      2'h0: begin
        up = (br & a) | (bf & ~a) | (ar & ~b) | (af & b);
        dn = (bf & a) | (br & ~a) | (ar & b) | (af & ~b);
      end
      2'h1: begin
        up = af & b;
        dn = af & ~b;
      end
      2'h2: begin
        up = af & b;
        dn = bf & a;
      end
      2'h3: begin
        up = (br & a) | (bf & ~a);
        dn = (bf & a) | (br & ~a);
      end
    endcase
    return {up, dn};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler, input synchronisers, sync enable register

  always_ff @(posedge CLOCK_IN) begin
    if (!RESET_N_IN) begin
      div_cnt <= 6'h00;
    end else begin
      div_cnt <= div_cnt + 6'h01;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (!RESET_N_IN) begin
      ext_s1   <= 4'h0;
      ext_s2   <= 4'h0;
      ext_d    <= 4'h0;
      pin_prev <= 12'h000;
    end else begin
      ext_s1   <= EXT_CLOCK_PIN_IN;
      ext_s2   <= ext_s1;
      ext_d    <= ext_s2;
      pin_prev <= WAVE_PIN_IN;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (!RESET_N_IN) begin
      sync_en <= PT_SYNC_RST;
    end else if (WR_IN && addr_ch == PT_SYNC_SLOT && addr_reg == PT_REG_SYNC) begin
      sync_en <= WDATA_IN[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read port: data valid only in the cycle after the strobe

  always_ff @(posedge CLOCK_IN) begin
    if (!RESET_N_IN) begin
      RDATA_OUT <= 16'h0000;
    end else begin
      RDATA_OUT <= 16'h0000;
      if (RD_IN) begin
        if (addr_ch == PT_SYNC_SLOT) begin
          if (addr_reg == PT_REG_SYNC) begin
            RDATA_OUT <= {13'h0000, sync_en};
          end
        end else begin
          unique case (addr_reg)
            PT_REG_CTRL:   RDATA_OUT <= ctrl_reg[addr_ch];
            PT_REG_IOCTL:  RDATA_OUT <= io_reg[addr_ch];
            PT_REG_STATUS: RDATA_OUT <= {9'h000, stat_reg[addr_ch]};
            PT_REG_COUNT:  RDATA_OUT <= cnt[addr_ch];
            PT_REG_CC_A:   RDATA_OUT <= cc_reg[addr_ch][0];
            PT_REG_CC_B:   RDATA_OUT <= cc_reg[addr_ch][1];
            PT_REG_CC_C:   RDATA_OUT <= cc_reg[addr_ch][2];
            PT_REG_CC_D:   RDATA_OUT <= cc_reg[addr_ch][3];
            default:       RDATA_OUT <= 16'h0000;
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channels

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    localparam int NREG = (c == 0) ? 4 : 2;

    pt_ctrl_s    ctl;
    logic        wr_ch;
    logic        psc_hit;
    logic        tick;
    logic        up_ev;
    logic        dn_ev;
    logic        phase_on;
    logic        cnt_wr;
    logic        sync_clr;
    logic        cleared;
    logic        ovf_set;
    logic        unf_set;
    logic [1:0]  buf_on;
    logic [1:0]  cyc;
    logic        cyc_ok;
    logic [3:0]  cmp_hit;
    logic [3:0]  cap_hit;
    logic [3:0]  evt;
    logic [15:0] next_cnt;

    assign ctl    = ctrl_reg[c];
    assign wr_ch  = WR_IN && addr_ch == 2'(c);
    assign buf_on = (c == 0) ? {ctl.buffer_b, ctl.buffer_a} : 2'b00;
    assign cyc    = 2'(ctl.clear_source - 3'h1);
    assign cyc_ok = ctl.clear_source != PT_CLR_NONE && ctl.clear_source < PT_CLR_SYNC
                    && ctl.clear_source <= 3'(NREG);

    always_comb begin
      unique case (ctl.prescale_select)
        3'h1:    psc_hit = (div_cnt & PT_DIV4_MASK) == PT_DIV4_MASK;
        3'h2:    psc_hit = (div_cnt & PT_DIV16_MASK) == PT_DIV16_MASK;
        3'h3:    psc_hit = (div_cnt & PT_DIV64_MASK) == PT_DIV64_MASK;
        default: psc_hit = 1'b1;
      endcase
    end

    if (c == 0) begin : g_noquad
      assign up_ev    = 1'b0;
      assign dn_ev    = 1'b0;
      assign phase_on = 1'b0;
    end else begin : g_quad
      assign {up_ev, dn_ev} = pt_quad(ctl.phase_variant,
                                      ext_s2[2*c-2], ext_s2[2*c-1],
                                      ext_d[2*c-2], ext_d[2*c-1]);
      assign phase_on = ctl.mode == PT_MODE_PHASE;
    end

    // Quadrature replaces the prescaled clock entirely
    assign tick = ctl.start && (phase_on ? (up_ev | dn_ev) : psc_hit);

    for (genvar k = 0; k < 4; k++) begin : g_evt
      logic [3:0] sel;
      logic       in_now;
      logic       in_old;
      assign sel    = io_reg[c][4*k+3 -: 4];
      assign in_now = WAVE_PIN_IN[4*c+k];
      assign in_old = pin_prev[4*c+k];
      // C/D raise no events of their own while buffering into A/B is on
      if (k < NREG) begin : g_live
        logic is_buf;
        assign is_buf     = (k >= 2) && buf_on[k%2];
        assign cmp_hit[k] = tick && !sel[PT_IO_CAPTURE] && !is_buf
                            && cnt[c] == cc_reg[c][k];
        assign cap_hit[k] = sel[PT_IO_CAPTURE] && !is_buf &&
                            ((sel[1:0] == PT_EDGE_RISE) ? (in_now & ~in_old) :
                             (sel[1:0] == PT_EDGE_FALL) ? (~in_now & in_old) :
                             (in_now ^ in_old));
      end else begin : g_dead
        assign cmp_hit[k] = 1'b0;
        assign cap_hit[k] = 1'b0;
      end
      assign evt[k] = cmp_hit[k] | cap_hit[k];
    end

    assign self_clr_v[c] = cyc_ok && evt[cyc];
    assign sync_clr = ctl.clear_source == PT_CLR_SYNC && sync_en[c]
                      && |(self_clr_v & sync_en[NUM_CH-1:0]);
    assign cleared  = self_clr_v[c] || sync_clr;
    assign cnt_wr   = (wr_ch && addr_reg == PT_REG_COUNT) || (sync_en[c] && sync_cnt_wr);
    assign ovf_set  = !cnt_wr && !cleared && tick && !(phase_on && dn_ev)
                      && cnt[c] == 16'hffff;
    assign unf_set  = !cnt_wr && !cleared && tick && phase_on && dn_ev
                      && cnt[c] == 16'h0000;

    always_comb begin
      next_cnt = cnt[c];
      if (cnt_wr) begin
        next_cnt = WDATA_IN;
      end else if (cleared) begin
        next_cnt = 16'h0000;
      end else if (tick && phase_on && dn_ev) begin
        next_cnt = cnt[c] - 16'h0001;
      end else if (tick) begin
        next_cnt = cnt[c] + 16'h0001;
      end
    end

    always_ff @(posedge CLOCK_IN) begin
      if (!RESET_N_IN) begin
        cnt[c] <= 16'h0000;
      end else begin
        cnt[c] <= next_cnt;
      end
    end

    always_ff @(posedge CLOCK_IN) begin
      if (!RESET_N_IN) begin
        ctrl_reg[c] <= pt_ctrl_s'(PT_CTRL_RST);
        io_reg[c]   <= PT_IOCTL_RST;
      end else if (wr_ch) begin
        if (addr_reg == PT_REG_CTRL) begin
          ctrl_reg[c] <= pt_ctrl_s'(WDATA_IN);
        end
        if (addr_reg == PT_REG_IOCTL) begin
          io_reg[c] <= WDATA_IN;
        end
      end
    end

    // Writing 0 clears a flag; a same-cycle hardware event wins
    always_ff @(posedge CLOCK_IN) begin
      if (!RESET_N_IN) begin
        stat_reg[c] <= PT_STATUS_RST;
      end else begin
        if (wr_ch && addr_reg == PT_REG_STATUS) begin
          stat_reg[c][PT_ST_UNF:0] <= (stat_reg[c][PT_ST_UNF:0] & WDATA_IN[PT_ST_UNF:0])
                                      | {unf_set, ovf_set, evt};
        end else begin
          stat_reg[c][PT_ST_UNF:0] <= stat_reg[c][PT_ST_UNF:0] | {unf_set, ovf_set, evt};
        end
        if (!phase_on) begin
          stat_reg[c][PT_ST_DIR] <= 1'b1;
        end else if (up_ev) begin
          stat_reg[c][PT_ST_DIR] <= 1'b1;
        end else if (dn_ev) begin
          stat_reg[c][PT_ST_DIR] <= 1'b0;
        end
      end
    end

    ////////////////////////////////////////////////////////////////////////
    // Compare/capture registers and their pins

    for (genvar k = 0; k < 4; k++) begin : g_reg
      localparam int KP = (k % 2 == 0) ? k + 1 : k - 1;
      localparam int KB = k % 2;
      localparam logic [3:0] OWN_ADDR = PT_REG_CC_A + 4'(k);
      localparam bit PAIR_HEAD = (k == 0) || (k == 2 && NREG == 4);
      logic [3:0] sel;
      logic [3:0] sel_p;
      logic       pair_ne;
      logic       duty_ne;
      assign sel     = io_reg[c][4*k+3 -: 4];
      assign sel_p   = io_reg[c][4*KP+3 -: 4];
      assign pair_ne = cc_reg[c][k] != cc_reg[c][KP];
      assign duty_ne = !cyc_ok || cc_reg[c][k] != cc_reg[c][cyc];

      if (k < NREG) begin : g_store
        always_ff @(posedge CLOCK_IN) begin
          if (!RESET_N_IN) begin
            cc_reg[c][k] <= 16'h0000;
          end else if (cap_hit[k]) begin
            cc_reg[c][k] <= cnt[c];
          end else if (k < 2 && buf_on[KB] && cmp_hit[k]) begin
            cc_reg[c][k] <= cc_reg[c][(k + 2) % 4];
          end else if (k >= 2 && buf_on[KB] && cap_hit[KB]) begin
            cc_reg[c][k] <= cc_reg[c][KB];
          end else if (wr_ch && addr_reg == OWN_ADDR) begin
            cc_reg[c][k] <= WDATA_IN;
          end
        end
      end else begin : g_absent
        always_ff @(posedge CLOCK_IN) begin
          cc_reg[c][k] <= 16'h0000;
        end
      end

      always_ff @(posedge CLOCK_IN) begin
        if (!RESET_N_IN) begin
          WAVE_PIN_OUT[4*c+k]      <= 1'b0;
          WAVE_PIN_OE_N_OUT[4*c+k] <= 1'b1;
        end else if (k >= NREG) begin
          WAVE_PIN_OUT[4*c+k]      <= 1'b0;
          WAVE_PIN_OE_N_OUT[4*c+k] <= 1'b1;
        end else begin
          unique case (ctl.mode)
            PT_MODE_NORMAL, PT_MODE_PHASE: begin
              WAVE_PIN_OE_N_OUT[4*c+k] <= sel[PT_IO_CAPTURE] || sel[1:0] == PT_ACT_NONE;
              if (!ctl.start) begin
                WAVE_PIN_OUT[4*c+k] <= sel[PT_IO_INIT];
              end else if (cmp_hit[k]) begin
                WAVE_PIN_OUT[4*c+k] <= pt_apply(WAVE_PIN_OUT[4*c+k], sel[1:0]);
              end
            end
            PT_MODE_PWM1: begin
              // Only pair heads drive a pin, so at most four phases exist
              if (PAIR_HEAD) begin
                WAVE_PIN_OE_N_OUT[4*c+k] <= 1'b0;
                if (!ctl.start) begin
                  WAVE_PIN_OUT[4*c+k] <= sel[PT_IO_INIT];
                end else if (cmp_hit[k] && pair_ne) begin
                  WAVE_PIN_OUT[4*c+k] <= pt_apply(WAVE_PIN_OUT[4*c+k], sel[1:0]);
                end else if (cmp_hit[KP] && pair_ne) begin
                  WAVE_PIN_OUT[4*c+k] <= pt_apply(WAVE_PIN_OUT[4*c+k], sel_p[1:0]);
                end
              end else begin
                WAVE_PIN_OUT[4*c+k]      <= 1'b0;
                WAVE_PIN_OE_N_OUT[4*c+k] <= 1'b1;
              end
            end
            PT_MODE_PWM2: begin
              if (cyc_ok && cyc == 2'(k)) begin
                WAVE_PIN_OUT[4*c+k]      <= 1'b0;
                WAVE_PIN_OE_N_OUT[4*c+k] <= 1'b1;
              end else begin
                // Every non-cycle register drives, giving up to seven phases
                WAVE_PIN_OE_N_OUT[4*c+k] <= 1'b0;
                if (!ctl.start || cleared) begin
                  WAVE_PIN_OUT[4*c+k] <= sel[PT_IO_INIT];
                end else if (cmp_hit[k] && duty_ne) begin
                  WAVE_PIN_OUT[4*c+k] <= pt_apply(WAVE_PIN_OUT[4*c+k], sel[1:0]);
                end
              end
            end
          endcase
        end
      end
    end
  end

  // Channel 3 pins do not exist; channel pins above 4*NUM_CH unused
endmodule // pt_pulse_timer_unit

/* File: sim/pt_pins_model.sv */
// Pin-side model: quadrature encoder on the external clock pins and the wave pin wires
`timescale 1ns/1ps
module pt_pins_model (
  input  wire logic        clk_in,
  input  wire logic        step_in,
  input  wire logic        dir_in,
  input  wire logic        chan_in,
  input  wire logic [11:0] drive_in,
  input  wire logic [11:0] pin_out_in,
  input  wire logic [11:0] pin_oe_n_in,
  output logic      [11:0] wave_pin_out,
  output logic      [3:0]  ext_clock_out
);
  logic [1:0] pos [2] = '{2'h0, 2'h0};

  // Gray order 00, 10, 11, 01 on (A,B) is an up count in variant 1
  function automatic logic [1:0] phase_ab(input logic [1:0] p);
    return p ^ {1'b0, p[1]};
  endfunction

  always_ff @(posedge clk_in) begin
    if (step_in) begin
      pos[chan_in] <= dir_in ? pos[chan_in] + 2'h1 : pos[chan_in] - 2'h1;
    end
  end

  assign ext_clock_out = {phase_ab(pos[1]), phase_ab(pos[0])};
  // A released pin follows the outside driver, a driven one the device
  assign wave_pin_out = (pin_oe_n_in & drive_in) | (~pin_oe_n_in & pin_out_in);
endmodule // pt_pins_model

/* File: sim/pt_unit_asserts.sv */
// Port checker for the pulse timer unit
`timescale 1ns/1ps
module pt_unit_asserts
  import pt_pkg::*;
(
  input wire logic        CLOCK_IN,
  input wire logic        RESET_N_IN,
  input wire logic [5:0]  ADDR_IN,
  input wire logic [15:0] WDATA_IN,
  input wire logic        WR_IN,
  input wire logic        RD_IN,
  input wire logic [15:0] RDATA_OUT,
  input wire logic [11:0] WAVE_PIN_IN,
  input wire logic [11:0] WAVE_PIN_OUT,
  input wire logic [11:0] WAVE_PIN_OE_N_OUT,
  input wire logic [3:0]  EXT_CLOCK_PIN_IN
);
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RESET_N_IN);

  a_rdata_idle: assert property (!RD_IN |=> RDATA_OUT == 16'h0000)
    else $error("read data not zero outside a read");
  a_reset_pins: assert property (disable iff (1'b0)
    !RESET_N_IN |=> WAVE_PIN_OE_N_OUT == 12'hfff && WAVE_PIN_OUT == 12'h000)
    else $error("pins not released in reset");
  a_unused_pins: assert property ((WAVE_PIN_OE_N_OUT & 12'hcc0) == 12'hcc0
    && (WAVE_PIN_OUT & 12'hcc0) == 12'h000) else $error("unused pin driven");
  a_oe_from_cfg: assert property (!$stable(WAVE_PIN_OE_N_OUT)
    |-> $past(WR_IN) || $past(WR_IN, 2) || $past(WR_IN, 3))
    else $error("pin enable changed without a write");
  a_unmapped_zero: assert property (RD_IN && ADDR_IN[3] |=> RDATA_OUT == 16'h0000)
    else $error("unmapped read not zero");
  a_status_width: assert property (RD_IN && ADDR_IN[3:0] == PT_REG_STATUS
    && ADDR_IN[5:4] != PT_SYNC_SLOT |=> RDATA_OUT[15:7] == 9'h000)
    else $error("status upper bits set");
  a_ch12_cd_zero: assert property (RD_IN && ADDR_IN[5:4] inside {2'h1, 2'h2}
    && ADDR_IN[3:1] == 3'h3 |=> RDATA_OUT == 16'h0000) else $error("absent register not zero");
  a_sync_width: assert property (RD_IN && ADDR_IN == 6'h30
    |=> RDATA_OUT[15:3] == 13'h0000) else $error("sync upper bits set");
endmodule // pt_unit_asserts

/* File: sim/pt_pulse_timer_unit_tb.sv */
// Self-checking testbench of the pulse timer unit
`timescale 1ns/1ps
module pt_pulse_timer_unit_tb;
  logic        clk, rst_n, wr, rd, step, dir, chan;
  logic [5:0]  addr, base;
  logic [15:0] wdata, rdata, cap;
  logic [11:0] pout, poe, pin, drive;
  logic [3:0]  ext;
  logic [31:0] seed;
  int          mismatches, tests_run, cycles, n;

  pt_pulse_timer_unit #(.NUM_CH(3)) i_pt_pulse_timer_unit (.CLOCK_IN(clk), .RESET_N_IN(rst_n),
    .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
    .WAVE_PIN_IN(pin), .WAVE_PIN_OUT(pout), .WAVE_PIN_OE_N_OUT(poe), .EXT_CLOCK_PIN_IN(ext));
  pt_pins_model i_pt_pins_model (.clk_in(clk), .step_in(step), .dir_in(dir), .chan_in(chan),
    .drive_in(drive), .pin_out_in(pout), .pin_oe_n_in(poe), .wave_pin_out(pin),
    .ext_clock_out(ext));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr_reg(input logic [5:0] a, input logic [15:0] d);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdc(input logic [5:0] a, input logic [15:0] m, input logic [15:0] e,
                     input string nm);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(nm, e, rdata & m);
    @(posedge clk);
  endtask

  // One encoder step, then time for synchroniser and edge detector
  task automatic enc_step(input logic d, input logic c);
    dir <= d; chan <= c; step <= 1'b1;
    @(posedge clk);
    step <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  // High cycles in ten periods of ten counts: pin set after count rise, cleared after fall
  function automatic logic [15:0] high_cycles(input int rise, input int fall);
    return 16'(10 * (fall - rise));
  endfunction

  // Cycles with pin p high over ten periods of ten counts
  task automatic hicount(input int p, input logic [15:0] e);
    int k = 0;
    repeat (30) @(posedge clk);
    repeat (100) begin
      @(posedge clk);
      #1;
      if (pout[p] === 1'b1) k++;
    end
    check("pin high cycles", e, 16'(k));
    @(posedge clk);
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      stop_test();
    end
  end

  initial begin
    rst_n = 1'b0; addr = 6'h00; wdata = 16'h0000; wr = 1'b0; rd = 1'b0; step = 1'b0;
    dir = 1'b0; chan = 1'b0; drive = 12'h000; seed = 32'he499aafd; cycles = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdc(6'h00, 16'hffff, 16'h0000, "ctrl0");
    rdc(6'h02, 16'hffff, 16'h0040, "status0");
    rdc(6'h08, 16'hffff, 16'h0000, "unmapped");
    rdc(6'h16, 16'hffff, 16'h0000, "ch1 reg c");
    rdc(6'h30, 16'hffff, 16'h0000, "sync");
    // Mode 2 on channel 1, cycle on reg A, duty B drives high
    wr_reg(6'h10, 16'h0220);
    wr_reg(6'h11, 16'h0020);
    repeat (3) @(posedge clk);
    #1;
    check("pin enables", 16'h0fdf, {4'h0, poe});
    @(posedge clk);
    // Mode 1 on channel 0, buffer A from C, period 10 by clear on B
    wr_reg(6'h04, 16'h0003);
    wr_reg(6'h05, 16'h0009);
    wr_reg(6'h06, 16'h0005);
    wr_reg(6'h01, 16'h0016);
    wr_reg(6'h00, 16'h1140);
    repeat (3) @(posedge clk);
    #1;
    check("pin a at init", 16'h0001, {14'h0, poe[0], pout[0]});
    @(posedge clk);
    wr_reg(6'h01, 16'h0012);
    wr_reg(6'h00, 16'h5140);
    hicount(0, high_cycles(5, 9));
    rdc(6'h04, 16'hffff, 16'h0005, "buffered reg a");
    wr_reg(6'h06, 16'h0009);
    hicount(0, 16'd100);
    // Capture with buffer on a stopped counter
    wr_reg(6'h00, 16'h0000);
    wr_reg(6'h01, 16'h0008);
    wr_reg(6'h00, 16'h1000);
    wr_reg(6'h03, 16'h1234);
    drive[0] <= 1'b1;
    repeat (4) @(posedge clk);
    drive[0] <= 1'b0;
    seed = xorshift(seed);
    cap = seed[15:0];
    wr_reg(6'h03, cap);
    drive[0] <= 1'b1;
    repeat (4) @(posedge clk);
    rdc(6'h04, 16'hffff, cap, "captured reg a");
    rdc(6'h06, 16'hffff, 16'h1234, "buffer reg c");
    // Mode 2 on channel 1: cycle A = 9, duty B = 6 toggles, cycle clear restores init
    wr_reg(6'h14, 16'h0009);
    wr_reg(6'h15, 16'h0006);
    wr_reg(6'h11, 16'h0030);
    wr_reg(6'h10, 16'h4220);
    hicount(5, high_cycles(6, 9));
    wr_reg(6'h11, 16'h0070);
    hicount(5, 16'd100 - high_cycles(6, 9));
    wr_reg(6'h15, 16'h0009);
    hicount(5, 16'd100);
    rdc(6'h12, 16'h0001, 16'h0001, "cycle match flag");
    // Quadrature on channels 1 and 2, prescaler set to divide by 64
    for (int c = 0; c < 2; c++) begin
      base = 6'((c + 1) * 16);
      wr_reg(base, 16'h4303);
      wr_reg(base + 6'h3, 16'h0000);
      seed = xorshift(seed);
      n = int'(seed[3:0]) + 1;
      repeat (n) enc_step(1'b1, c[0]);
      rdc(base + 6'h3, 16'hffff, 16'(n), "count up");
      rdc(base + 6'h2, 16'h0070, 16'h0040, "status up");
      repeat (n + 3) enc_step(1'b0, c[0]);
      rdc(base + 6'h3, 16'hffff, 16'hfffd, "count down");
      rdc(base + 6'h2, 16'h0070, 16'h0020, "status down");
      wr_reg(base + 6'h3, 16'hffff);
      enc_step(1'b1, c[0]);
      rdc(base + 6'h3, 16'hffff, 16'h0000, "count wrap");
      rdc(base + 6'h2, 16'h0070, 16'h0070, "status wrap");
    end
    rdc(6'h13, 16'hffff, 16'h0000, "ch1 count kept");
    stop_test();
  end
endmodule // pt_pulse_timer_unit_tb

bind pt_pulse_timer_unit pt_unit_asserts i_pt_unit_asserts (.CLOCK_IN(CLOCK_IN),
  .RESET_N_IN(RESET_N_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN),
  .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT), .WAVE_PIN_IN(WAVE_PIN_IN),
  .WAVE_PIN_OUT(WAVE_PIN_OUT), .WAVE_PIN_OE_N_OUT(WAVE_PIN_OE_N_OUT),
  .EXT_CLOCK_PIN_IN(EXT_CLOCK_PIN_IN));
